// ===== blsmb_duty.sv
// Duty-cycle meter for the brightness input pin
`timescale 1ns/1ps
module blsmb_duty
  import blsmb_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic level,
  input wire logic restart,
  output logic [7:0] duty_q
);

  logic [BLSMB_DUTY_WIN_LOG2-1:0] win_q;
  logic [BLSMB_DUTY_WIN_LOG2:0] high_q;
  logic [BLSMB_DUTY_WIN_LOG2:0] sum;

  // High time of the window, including this cycle
  assign sum = high_q + {{BLSMB_DUTY_WIN_LOG2{1'b0}}, level};

  // Fixed window keeps the meter free of a divider; the price is a
  // slow answer at low input frequencies
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      win_q <= '0;
      high_q <= '0;
      duty_q <= BLSMB_DUTY_FULL;
    end else if (restart) begin
      win_q <= '0;
      high_q <= '0;
      duty_q <= BLSMB_DUTY_FULL;
    end else begin
      win_q <= win_q + 1'b1;
      if (&win_q) begin
        high_q <= '0;
        if (sum[BLSMB_DUTY_WIN_LOG2]) begin
          duty_q <= BLSMB_DUTY_FULL;
        end else begin
          duty_q <= sum[BLSMB_DUTY_WIN_LOG2-1 -: 8];
        end
      end else begin
        high_q <= sum;
      end
    end
  end

endmodule

// ===== blsmb_host.sv
// Host bus master model for the backlight register bank
`timescale 1ns/1ps
module blsmb_host
  import blsmb_pkg::*;
(
  output logic scl,
  output wire sda,
  input wire logic dev_out,
  input wire logic dev_oe
);
  // ****************************************************************
  // Line and bit timing
  // ****************************************************************
  logic pull_q = 1'b0;
  // Pull-up wins when nobody pulls; device owns its own slots
  assign sda = dev_oe ? dev_out : !pull_q;
  // Board straps taken as set for serial control; the bank sees none
  // Clock idles high before the first frame, low after each stop,
  // since the engine only notices a stop at a clock fall
  initial scl = 1'b1;
  // Data moves while clock is low, sampled at the rise
  task automatic bit_x(input logic b, output logic r);
    #12 pull_q = !b;
    #12 scl = 1'b1;
    r = sda;
    #24 scl = 1'b0;
  endtask
  // Start or repeated start: data falls while clock is high
  task automatic start;
    pull_q = 1'b0;
    #12 scl = 1'b1;
    #12 pull_q = 1'b1;
    #12 scl = 1'b0;
  endtask
  task automatic stop;
    #12 pull_q = 1'b1;
    #12 scl = 1'b1;
    #12 pull_q = 1'b0;
    #12 scl = 1'b0;
  endtask
  // Eight bits then the ninth slot; host releases it (nack on reads)
  task automatic xfer(input logic [7:0] w, output logic [7:0] r, output logic a);
    for (int i = 7; i >= 0; i--) begin
      bit_x(w[i], r[i]);
    end
    bit_x(1'b1, a);
  endtask
  // Three-byte write frame
  task automatic wr(input logic [7:0] a, input logic [7:0] i, input logic [7:0] d,
                    output logic [2:0] k);
    logic [7:0] r;
    start;
    xfer(a, r, k[2]);
    xfer(i, r, k[1]);
    xfer(d, r, k[0]);
    stop;
  endtask
  // Four-byte read frame with turnaround
  task automatic rd(input logic [7:0] i, output logic [7:0] d, output logic [2:0] k);
    logic [7:0] r;
    logic n;
    start;
    xfer(BLSMB_ADDR_WR, r, k[2]);
    xfer(i, r, k[1]);
    start;
    xfer(BLSMB_ADDR_RD, r, k[0]);
    xfer(8'hff, d, n);
    stop;
  endtask
endmodule

// ===== blsmb_pkg.sv
// Shared constants and types for the backlight serial register bank
package blsmb_pkg;

  // ****************************************************************
  // Bus addressing and register map
  // ****************************************************************
  localparam logic [7:0] BLSMB_ADDR_WR = 8'h58;
  localparam logic [7:0] BLSMB_ADDR_RD = 8'h59;
  localparam logic [7:0] BLSMB_IDX_BRIGHT = 8'h00;
  localparam logic [7:0] BLSMB_IDX_CTRL = 8'h01;
  localparam logic [7:0] BLSMB_IDX_STATUS = 8'h02;
  localparam logic [7:0] BLSMB_IDX_IDENT = 8'h03;

  // ****************************************************************
  // Field positions and values after reset
  // ****************************************************************
  localparam logic [7:0] BLSMB_BRIGHT_RST = 8'hff;
  localparam logic [2:0] BLSMB_CTRL_RST = 3'h0;
  localparam int BLSMB_CTRL_SWITCH = 0;
  localparam int BLSMB_CTRL_SOURCE = 1;
  localparam int BLSMB_CTRL_INTERP = 2;
  localparam logic BLSMB_ID_PANEL = 1'b1;
  localparam logic [7:0] BLSMB_DUTY_FULL = 8'hff;
  localparam logic [2:0] BLSMB_BIT_LAST = 3'h7;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int BLSMB_SYS_KHZ = 50000;
  localparam int BLSMB_TURN_ON_MS = 10;
  localparam int BLSMB_TURN_ON_CYC = BLSMB_TURN_ON_MS * BLSMB_SYS_KHZ;
  localparam int BLSMB_DUTY_WIN_LOG2 = 16;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [2:0] {
    BLSMB_MODE_PWM = 3'b001,
    BLSMB_MODE_SERIAL = 3'b010,
    BLSMB_MODE_SCALED = 3'b100
  } blsmb_mode_type;

  typedef enum logic [8:0] {
    BLSMB_ST_IDLE = 9'b000000001,
    BLSMB_ST_ADDR = 9'b000000010,
    BLSMB_ST_ACK_A = 9'b000000100,
    BLSMB_ST_CMD = 9'b000001000,
    BLSMB_ST_ACK_C = 9'b000010000,
    BLSMB_ST_WDATA = 9'b000100000,
    BLSMB_ST_ACK_D = 9'b001000000,
    BLSMB_ST_RDATA = 9'b010000000,
    BLSMB_ST_RACK = 9'b100000000
  } blsmb_link_type;

  typedef struct packed {
    logic [7:0] idx;
    logic [7:0] data;
  } blsmb_wr_type;

  typedef struct packed {
    logic two_off;
    logic one_off;
    logic lit;
    logic ovc;
    logic heat;
    logic fault;
  } blsmb_status_type;

endpackage

// ===== blsmb_regs.sv
// Serial register bank and protection logic of the LED backlight driver
//
// What this block does
// - Read: address, command, address-read, data returned
// - Write: address, command, then data stored
// - Device drives data only for acks, read data
// - Answer address byte 0x58 write, 0x59 read
// - Four byte registers at commands 0x00 to 0x03
// - Brightness byte, 0xff brightest, resets to 0xff
// - Brightness write acts in serial and scaled modes
// - Brightness read returns held level always
// - Switch bit: on within 10 ms, off immediately
// - Bits 1 and 2 select the operating mode
// - Scaled mode: brightness times measured input duty
// - Bit 2 set: input ignored unless input mode
// - Control bits 7..3 read zero; reset 0x00
// - Status bit 0 is OR of faults
// - Status bit 3 shows backlight on
// - Status bit 2 shows input overcurrent present
// - Status bits 5..4 count disabled strings
// - Status read-only, bits 7..6 zero, reset 0x00
// - Identity holds maker field and revision field
// - Low headroom at overvoltage limit disables string
// - High headroom disables a shorted string
// - Overheat shuts down, sets bit 1, self-restarts
// - Identity bit 7 one, bits 2..0 revision
`timescale 1ns/1ps
module blsmb_regs
  import blsmb_pkg::*;
#(
  parameter int ON_DELAY_CYCLES = BLSMB_TURN_ON_CYC,
  parameter logic [3:0] MAKER_ID = 4'h0, // arbitrary value
  parameter logic [2:0] REVISION = 3'h0
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic duty_in,
  input wire logic [7:0] open_string_guard,
  input wire logic [7:0] shorted_string_guard,
  input wire logic output_overvoltage_limit,
  input wire logic overheat_hot,
  input wire logic overheat_cool,
  input wire logic input_overcurrent,
  output logic [7:0] string_enable,
  output logic [7:0] brightness_out,
  output logic shutdown
);

  // ****************************************************************
  // Helpers
  // ****************************************************************
  localparam int DLY_W = $clog2(ON_DELAY_CYCLES + 1);
  localparam logic [DLY_W-1:0] DELAY_LAST = DLY_W'(ON_DELAY_CYCLES - 1);

  // Operating mode from the control bits
  function automatic blsmb_mode_type mode_of(input logic [2:0] c);
    if (c[BLSMB_CTRL_SOURCE]) begin
      mode_of = BLSMB_MODE_PWM;
    end else if (c[BLSMB_CTRL_INTERP]) begin
      mode_of = BLSMB_MODE_SERIAL;
    end else begin
      mode_of = BLSMB_MODE_SCALED;
    end
  endfunction

  // Disabled-string count coded as none, one, two or more
  function automatic logic [1:0] off_code(input logic [7:0] d);
    int n;
    n = 0;
    for (int i = 0; i < 8; i++) begin
      n = n + int'(d[i]);
    end
    off_code = (n == 0) ? 2'b00 : ((n == 1) ? 2'b01 : 2'b11);
  endfunction

  // ****************************************************************
  // Link domain: serial engine on the bus clock
  // ****************************************************************
  blsmb_link_type state_q;
  logic [2:0] cnt_q;
  logic [7:0] sh_q;
  logic [7:0] tx_q;
  logic bit_q;
  logic is_read_q;
  logic have_cmd_q;
  logic [7:0] link_idx_q;
  blsmb_wr_type wr_q;
  logic wr_tgl_q;
  logic rd_tgl_q;
  logic [7:0] rd_word_q;
  logic drive_oe;
  logic drive_out;
  logic [7:0] byte_in;
  logic start_seen;
  logic stop_seen;
  logic byte_done;
  logic addr_ok;

  // Data is sampled while the clock is high
  always_ff @(posedge scl or negedge rst_n) begin
    if (!rst_n) begin
      bit_q <= 1'b1;
    end else begin
      bit_q <= sda_in;
    end
  end

  // Data moving during the high phase marks start or stop
  assign start_seen = bit_q & ~sda_in;
  assign stop_seen = ~bit_q & sda_in;
  assign byte_in = {sh_q[6:0], bit_q};
  assign byte_done = (cnt_q == BLSMB_BIT_LAST);
  // Read address is only valid after a command code
  assign addr_ok = (byte_in[7:1] == BLSMB_ADDR_WR[7:1]) &&
                   ((byte_in == BLSMB_ADDR_WR) ||
                    ((byte_in == BLSMB_ADDR_RD) && have_cmd_q));

  // Protocol sequencer, advanced on the falling edge
  always_ff @(negedge scl or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= BLSMB_ST_IDLE;
      cnt_q <= 3'h0;
      sh_q <= 8'h00;
      tx_q <= 8'h00;
      is_read_q <= 1'b0;
      have_cmd_q <= 1'b0;
    end else if (start_seen) begin
      state_q <= BLSMB_ST_ADDR;
      cnt_q <= 3'h0;
    end else if (stop_seen) begin
      state_q <= BLSMB_ST_IDLE;
      have_cmd_q <= 1'b0;
    end else begin
      case (state_q)
        BLSMB_ST_ADDR: begin
          cnt_q <= cnt_q + 3'h1;
          sh_q <= byte_in;
          if (byte_done) begin
            state_q <= addr_ok ? BLSMB_ST_ACK_A : BLSMB_ST_IDLE;
            is_read_q <= byte_in[0];
          end
        end
        BLSMB_ST_ACK_A: begin
          tx_q <= rd_word_q;
          state_q <= is_read_q ? BLSMB_ST_RDATA : BLSMB_ST_CMD;
        end
        BLSMB_ST_CMD: begin
          cnt_q <= cnt_q + 3'h1;
          sh_q <= byte_in;
          if (byte_done) begin
            state_q <= BLSMB_ST_ACK_C;
            have_cmd_q <= 1'b1;
          end
        end
        BLSMB_ST_ACK_C: begin
          state_q <= BLSMB_ST_WDATA;
        end
        BLSMB_ST_WDATA: begin
          cnt_q <= cnt_q + 3'h1;
          sh_q <= byte_in;
          if (byte_done) begin
            state_q <= BLSMB_ST_ACK_D;
          end
        end
        BLSMB_ST_RDATA: begin
          cnt_q <= cnt_q + 3'h1;
          tx_q <= {tx_q[6:0], 1'b0};
          if (byte_done) begin
            state_q <= BLSMB_ST_RACK;
          end
        end
        default: begin
          state_q <= BLSMB_ST_IDLE;
          have_cmd_q <= 1'b0;
        end
      endcase
    end
  end

  // Line is driven only in ack and read-data slots
  always_comb begin
    drive_oe = 1'b0;
    drive_out = 1'b1;
    if (!start_seen && !stop_seen) begin
      if (byte_done && (((state_q == BLSMB_ST_ADDR) && addr_ok) ||
          (state_q == BLSMB_ST_CMD) || (state_q == BLSMB_ST_WDATA))) begin
        drive_oe = 1'b1;
        drive_out = 1'b0;
      end else if ((state_q == BLSMB_ST_ACK_A) && is_read_q) begin
        drive_oe = 1'b1;
        drive_out = rd_word_q[7];
      end else if ((state_q == BLSMB_ST_RDATA) && !byte_done) begin
        drive_oe = 1'b1;
        drive_out = tx_q[6];
      end
    end
  end

  // Pin drivers change only while the clock is low
  always_ff @(negedge scl or negedge rst_n) begin
    if (!rst_n) begin
      sda_oe <= 1'b0;
      sda_out <= 1'b1;
    end else begin
      sda_oe <= drive_oe;
      sda_out <= drive_out;
    end
  end

  // Requests to the system side; words stay put until the next toggle
  always_ff @(negedge scl or negedge rst_n) begin
    if (!rst_n) begin
      link_idx_q <= 8'h00;
      wr_q <= '0;
      wr_tgl_q <= 1'b0;
      rd_tgl_q <= 1'b0;
    end else if (!start_seen && !stop_seen && byte_done) begin
      if (state_q == BLSMB_ST_CMD) begin
        link_idx_q <= byte_in;
        rd_tgl_q <= ~rd_tgl_q;
      end else if (state_q == BLSMB_ST_WDATA) begin
        wr_q <= '{idx: link_idx_q, data: byte_in};
        wr_tgl_q <= ~wr_tgl_q;
      end
    end
  end

  // ****************************************************************
  // System domain: crossings and pin synchronisers
  // ****************************************************************
  logic [1:0] tgl_s;
  logic [1:0] tgl_prev_q;
  logic wr_seen;
  logic rd_seen;
  logic duty_s;
  logic [7:0] open_s;
  logic [7:0] short_s;
  logic limit_s;
  logic hot_s;
  logic cool_s;
  logic ovc_s;

  blsmb_sync #(.W(2)) u_tgl_sync (
    .clk(sys_clk),
    .rst_n(rst_n),
    .d({wr_tgl_q, rd_tgl_q}),
    .q(tgl_s)
  );

  blsmb_sync #(.W(21)) u_pin_sync (
    .clk(sys_clk),
    .rst_n(rst_n),
    .d({duty_in, open_string_guard, shorted_string_guard,
        output_overvoltage_limit, overheat_hot, overheat_cool,
        input_overcurrent}),
    .q({duty_s, open_s, short_s, limit_s, hot_s, cool_s, ovc_s})
  );

  // Toggle edges mark one request each
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tgl_prev_q <= 2'b00;
    end else begin
      tgl_prev_q <= tgl_s;
    end
  end
  assign wr_seen = tgl_s[1] ^ tgl_prev_q[1];
  assign rd_seen = tgl_s[0] ^ tgl_prev_q[0];

  // ****************************************************************
  // Registers
  // ****************************************************************
  logic [7:0] bright_q;
  logic [2:0] ctrl_q;
  blsmb_status_type status_q;
  blsmb_mode_type mode;
  blsmb_mode_type mode_q;

  // Brightness level, every bit writable
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      bright_q <= BLSMB_BRIGHT_RST;
    end else if (wr_seen && (wr_q.idx == BLSMB_IDX_BRIGHT)) begin
      bright_q <= wr_q.data;
    end
  end

  // Only the three live control bits are stored
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= BLSMB_CTRL_RST;
    end else if (wr_seen && (wr_q.idx == BLSMB_IDX_CTRL)) begin
      ctrl_q <= wr_q.data[2:0];
    end
  end

  // Read word built on request; the link uses it at least a byte
  // time later, long after this settles
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_word_q <= 8'h00;
    end else if (rd_seen) begin
      case (link_idx_q)
        BLSMB_IDX_BRIGHT: rd_word_q <= bright_q;
        BLSMB_IDX_CTRL: rd_word_q <= {5'h00, ctrl_q};
        BLSMB_IDX_STATUS: rd_word_q <= {2'b00, status_q};
        BLSMB_IDX_IDENT: rd_word_q <= {BLSMB_ID_PANEL, MAKER_ID, REVISION};
        default: rd_word_q <= 8'h00;
      endcase
    end
  end

  // ****************************************************************
  // Mode and brightness path
  // ****************************************************************
  logic [7:0] duty_val;
  logic [15:0] product;
  logic [15:0] scaled;

  assign mode = mode_of(ctrl_q);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_q <= BLSMB_MODE_SCALED;
    end else begin
      mode_q <= mode;
    end
  end

  // Entering scaled mode restarts the meter at full duty
  blsmb_duty u_duty (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .level(duty_s),
    .restart((mode == BLSMB_MODE_SCALED) && (mode_q != BLSMB_MODE_SCALED)),
    .duty_q(duty_val)
  );

  // Rounded divide by 255, so full scale stays full scale
  assign product = bright_q * duty_val;
  assign scaled = (product + {8'h00, product[15:8]} + 16'h0080) >> 8;

  // Brightness that reaches the dimming logic
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      brightness_out <= BLSMB_BRIGHT_RST;
    end else begin
      case (mode)
        BLSMB_MODE_PWM: brightness_out <= duty_val;
        BLSMB_MODE_SERIAL: brightness_out <= bright_q;
        BLSMB_MODE_SCALED: brightness_out <= scaled[7:0];
        default: brightness_out <= bright_q;
      endcase
    end
  end

  // ****************************************************************
  // Backlight switch and protection
  // ****************************************************************
  logic [DLY_W-1:0] delay_cnt_q;
  logic on_q;
  logic overheat_q;
  logic [7:0] disabled_q;
  logic [1:0] off_cnt;

  // Turn-on wait counts only while the switch is set
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      delay_cnt_q <= '0;
    end else if (!ctrl_q[BLSMB_CTRL_SWITCH]) begin
      delay_cnt_q <= '0;
    end else if (delay_cnt_q != DELAY_LAST) begin
      delay_cnt_q <= delay_cnt_q + 1'b1;
    end
  end

  // Off is immediate; overheat also forces off
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      on_q <= 1'b0;
    end else begin
      on_q <= ctrl_q[BLSMB_CTRL_SWITCH] && (delay_cnt_q == DELAY_LAST) && !overheat_q;
    end
  end

  // Hysteresis between the hot and cool indications
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      overheat_q <= 1'b0;
    end else if (hot_s) begin
      overheat_q <= 1'b1;
    end else if (cool_s) begin
      overheat_q <= 1'b0;
    end
  end

  // Per-string disable; a fault seen while lit wins over the clear
  generate
    for (genvar i = 0; i < 8; i++) begin : g_string
      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          disabled_q[i] <= 1'b0;
        end else if (on_q && ((open_s[i] && limit_s) || short_s[i])) begin
          disabled_q[i] <= 1'b1;
        end else if (!ctrl_q[BLSMB_CTRL_SWITCH]) begin
          disabled_q[i] <= 1'b0;
        end
      end
    end
  endgenerate

  assign off_cnt = off_code(disabled_q);

  // Status is rebuilt every cycle from live conditions
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      status_q <= '0;
    end else begin
      status_q.heat <= overheat_q;
      status_q.ovc <= ovc_s;
      status_q.lit <= on_q;
      status_q.one_off <= off_cnt[0];
      status_q.two_off <= off_cnt[1];
      status_q.fault <= overheat_q | ovc_s | off_cnt[0];
    end
  end

  // Pin outputs
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      string_enable <= 8'h00;
      shutdown <= 1'b0;
    end else begin
      string_enable <= {8{on_q}} & ~disabled_q;
      shutdown <= overheat_q;
    end
  end

  // ****************************************************************
  // Assertions and covers
  // ****************************************************************
  bright_store_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    wr_seen && (wr_q.idx == BLSMB_IDX_BRIGHT) |=> bright_q == $past(wr_q.data))
    else $error("brightness write not stored");
  ctrl_store_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    wr_seen && (wr_q.idx == BLSMB_IDX_CTRL) |=> ctrl_q == $past(wr_q.data[2:0]))
    else $error("control write not stored");
  read_word_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    rd_seen && (link_idx_q == BLSMB_IDX_BRIGHT) |=> rd_word_q == $past(bright_q))
    else $error("read word does not hold brightness");
  serial_out_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    mode == BLSMB_MODE_SERIAL |=> brightness_out == $past(bright_q))
    else $error("serial brightness not applied");
  off_now_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !ctrl_q[BLSMB_CTRL_SWITCH] |=> !on_q ##1 !status_q.lit && string_enable == 8'h00)
    else $error("backlight not off at once");
  on_late_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(on_q) |-> $past(delay_cnt_q) == DELAY_LAST)
    else $error("backlight on before delay");
  fault_or_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    status_q.fault == (status_q.heat | status_q.ovc | status_q.one_off))
    else $error("fault bit not the OR of faults");
  two_off_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    status_q.two_off |-> status_q.one_off)
    else $error("string count code 10 seen");
  heat_stop_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    hot_s |=> overheat_q ##1 !on_q ##1 status_q.heat && shutdown)
    else $error("overheat did not shut down");
  scale_start_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (mode == BLSMB_MODE_SCALED) && (mode_q != BLSMB_MODE_SCALED) |=> duty_val == BLSMB_DUTY_FULL)
    else $error("scaled mode did not start at full duty");
  ack_slot_a: assert property (@(negedge scl) disable iff (!rst_n)
    sda_oe |-> state_q inside {BLSMB_ST_ACK_A, BLSMB_ST_ACK_C, BLSMB_ST_ACK_D, BLSMB_ST_RDATA})
    else $error("data line driven outside a device slot");
  addr_miss_a: assert property (@(negedge scl) disable iff (!rst_n)
    (state_q == BLSMB_ST_ADDR) && byte_done && !start_seen && !stop_seen && !addr_ok
    |=> !sda_oe && (state_q == BLSMB_ST_IDLE))
    else $error("foreign address acknowledged");

  bright_write_c: cover property (@(posedge sys_clk) disable iff (!rst_n)
    wr_seen && (wr_q.idx == BLSMB_IDX_BRIGHT));
  status_read_c: cover property (@(negedge scl) disable iff (!rst_n)
    (state_q == BLSMB_ST_RDATA) && (link_idx_q == BLSMB_IDX_STATUS));
  string_off_c: cover property (@(posedge sys_clk) disable iff (!rst_n)
    status_q.two_off);
  scaled_c: cover property (@(posedge sys_clk) disable iff (!rst_n)
    (mode == BLSMB_MODE_SCALED) && on_q && (duty_val != BLSMB_DUTY_FULL));

endmodule

// ===== blsmb_sync.sv
// Two-flop level synchroniser for a bundle of independent bits
`timescale 1ns/1ps
module blsmb_sync
  import blsmb_pkg::*;
#(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_q;

  // First stage feeds only the second stage
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      q <= '0;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end

endmodule

// ===== tb_top.sv
// Self-checking bench for the backlight register bank
`timescale 1ns/1ps
module tb_top;
  import blsmb_pkg::*;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic hot = 1'b0;
  logic cool = 1'b0;
  logic ovc = 1'b0;
  logic [7:0] sht = 8'h00;
  logic [7:0] opn = 8'h00;
  logic duty = 1'b1;
  logic lim = 1'b0;
  wire scl;
  wire sda;
  wire sda_o;
  wire sda_e;
  logic [7:0] string_enable;
  logic [7:0] brightness_out;
  logic shutdown;
  logic [7:0] d;
  logic [2:0] k;
  int errors = 0;
  int checked = 0;
  blsmb_regs #(.ON_DELAY_CYCLES(20)) dut (.sys_clk(sys_clk), .rst_n(rst_n),
    .scl(scl), .sda_in(sda), .sda_out(sda_o), .sda_oe(sda_e), .duty_in(duty),
    .open_string_guard(opn), .shorted_string_guard(sht),
    .output_overvoltage_limit(lim), .overheat_hot(hot), .overheat_cool(cool),
    .input_overcurrent(ovc), .string_enable(string_enable),
    .brightness_out(brightness_out), .shutdown(shutdown));
  blsmb_host host (.scl(scl), .sda(sda), .dev_out(sda_o), .dev_oe(sda_e));
  // ****************************************************************
  // Checking and verdict
  // ****************************************************************
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict;
    if (errors == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // Read one register, expect acks and a value
  task automatic rd_chk(input logic [7:0] i, input logic [7:0] exp);
    host.rd(i, d, k);
    check({5'h0, k}, 8'h00);
    check(d, exp);
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset;
    logic [7:0] exp [4] = '{8'hff, 8'h00, 8'h00, 8'h80};
    for (int i = 0; i < 4; i++) begin
      rd_chk(8'(i), exp[i]);
    end
  endtask
  // Reserved control bits drop; switch on, serial, input and scaled modes
  task automatic t_ctrl;
    host.wr(BLSMB_ADDR_WR, BLSMB_IDX_CTRL, 8'hfd, k);
    check({5'h0, k}, 8'h00);
    rd_chk(BLSMB_IDX_CTRL, 8'h05);
    wait_cyc(40);
    check(string_enable, 8'hff);
    rd_chk(BLSMB_IDX_STATUS, 8'h08);
    host.wr(BLSMB_ADDR_WR, BLSMB_IDX_BRIGHT, 8'h3c, k);
    wait_cyc(8);
    check(brightness_out, 8'h3c);
    rd_chk(BLSMB_IDX_BRIGHT, 8'h3c);
    host.wr(BLSMB_ADDR_WR, BLSMB_IDX_CTRL, 8'h03, k);
    wait_cyc(8);
    check(brightness_out, 8'hff);
    duty <= 1'b0;
    host.wr(BLSMB_ADDR_WR, BLSMB_IDX_CTRL, 8'h01, k);
    wait_cyc(8);
    check(brightness_out, 8'h3c);
    // One full meter window with the input pin held low
    wait_cyc(65536);
    check(brightness_out, 8'h00);
    duty <= 1'b1;
    host.wr(BLSMB_ADDR_WR, BLSMB_IDX_CTRL, 8'h05, k);
  endtask
  // Read-only status, unmapped index, foreign address
  task automatic t_refuse;
    host.wr(BLSMB_ADDR_WR, BLSMB_IDX_STATUS, 8'hff, k);
    rd_chk(BLSMB_IDX_STATUS, 8'h08);
    rd_chk(8'h07, 8'h00);
    host.wr(8'h5a, 8'h00, 8'h00, k);
    check({5'h0, k}, 8'h07);
  endtask
  // Overheat with hysteresis, then overcurrent and shorted strings
  task automatic t_faults;
    @(posedge sys_clk) hot <= 1'b1;
    wait_cyc(8);
    check({7'h0, shutdown}, 8'h01);
    rd_chk(BLSMB_IDX_STATUS, 8'h03);
    @(posedge sys_clk) hot <= 1'b0;
    wait_cyc(8);
    check({7'h0, shutdown}, 8'h01);
    @(posedge sys_clk) cool <= 1'b1;
    ovc <= 1'b1;
    wait_cyc(40);
    check({7'h0, shutdown}, 8'h00);
    rd_chk(BLSMB_IDX_STATUS, 8'h0d);
    @(posedge sys_clk) ovc <= 1'b0;
    sht <= 8'h03;
    wait_cyc(8);
    check(string_enable, 8'hfc);
    rd_chk(BLSMB_IDX_STATUS, 8'h39);
    @(posedge sys_clk) opn <= 8'h04;
    lim <= 1'b1;
    wait_cyc(8);
    check(string_enable, 8'hf8);
    host.wr(BLSMB_ADDR_WR, BLSMB_IDX_CTRL, 8'h04, k);
    wait_cyc(8);
    check(string_enable, 8'h00);
  endtask
  // Clock, reset and main sequence
  initial begin
    forever #10 sys_clk = ~sys_clk;
  end
  initial begin
    wait_cyc(2);
    rst_n <= 1'b1;
    wait_cyc(4);
    t_reset;
    t_ctrl;
    t_refuse;
    t_faults;
    print_verdict;
  end
  // Cut a hang well past the expected run length
  initial begin
    #1600000;
    errors++;
    print_verdict;
  end
endmodule
